// ### sce_event_regs.sv
`timescale 1ns/100ps
`include "sce_cfg.svh"
module sce_event_regs
  import sce_pkg::*;
#(
  parameter int SLOW_DIV = `SCE_CLK_HZ / `SCE_SLOW_HZ
)
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`SCE_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic irq,
  output sce_evt_t route_evt,
  output logic [`SCE_CHAN_N-1:0] chan_pulse,
  output logic running
);

  // Reset release through two flops; assertion stays asynchronous
  logic rst_meta_reg;
  logic rst_n_reg;

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      rst_meta_reg <= 1'b0;
      rst_n_reg <= 1'b0;
    end
    else
    begin
      rst_meta_reg <= 1'b1;
      rst_n_reg <= rst_meta_reg;
    end
  end

  // State
  logic [`SCE_EVT_N-1:0] flag_reg;
  logic [`SCE_EVT_N-1:0] irq_en_reg;
  logic [`SCE_EVT_N-1:0] route_reg;
  sce_pub_t pub_reg [`SCE_EVT_N];
  logic [`SCE_COUNT_W-1:0] match_reg [`SCE_MATCH_N];
  logic [`SCE_RATE_W-1:0] rate_reg;
  logic [`SCE_RATE_W-1:0] pre_cnt_reg;
  logic [`SCE_COUNT_W-1:0] count_reg;
  logic [`SCE_COUNT_W-1:0] snap_reg;
  logic [15:0] div_cnt_reg;
  logic run_reg;
  logic [1:0] wait_reg;
  logic pready_reg;
  logic [31:0] prdata_reg;
  logic irq_reg;
  logic [`SCE_EVT_N-1:0] route_pulse_reg;
  logic [`SCE_CHAN_N-1:0] chan_pulse_reg;

  // Bus phases: setup cycle, and the access cycle that completes
  wire setup_phase = psel & ~penable;
  wire access_done = psel & penable & pready_reg;
  wire wr_fire = access_done & pwrite;
  wire is_count_rd = setup_phase & ~pwrite & (paddr == `SCE_COUNT_OFS);

  // Register hits for single-instance registers
  wire hit_start = (paddr == `SCE_TASK_START_OFS);
  wire hit_stop = (paddr == `SCE_TASK_STOP_OFS);
  wire hit_clear = (paddr == `SCE_TASK_CLEAR_OFS);
  wire hit_near = (paddr == `SCE_TASK_NEAR_WRAP_OFS);
  wire hit_irq_set = (paddr == `SCE_IRQ_SET_OFS);
  wire hit_irq_clr = (paddr == `SCE_IRQ_CLR_OFS);
  wire hit_route = (paddr == `SCE_ROUTE_OFS);
  wire hit_route_set = (paddr == `SCE_ROUTE_SET_OFS);
  wire hit_route_clr = (paddr == `SCE_ROUTE_CLR_OFS);
  wire hit_rate = (paddr == `SCE_RATE_OFS);

  // Task strobes only act on a written 1, as a trigger
  wire do_start = wr_fire & hit_start & pwdata[0];
  wire do_stop = wr_fire & hit_stop & pwdata[0];
  wire do_clear = wr_fire & hit_clear & pwdata[0];
  wire do_near = wr_fire & hit_near & pwdata[0];

  // Slow clock stand-in: one-cycle enable every SLOW_DIV fast cycles
  wire slow_en = (div_cnt_reg == 16'(SLOW_DIV - 1));

  always_ff @(posedge clock or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
      div_cnt_reg <= 16'h0000;
    else if (slow_en)
      div_cnt_reg <= 16'h0000;
    else
      div_cnt_reg <= div_cnt_reg + 16'h0001;
  end

  // Counter advance: prescaler terminal count on a slow enable
  // Divider is compared for equality, so a change while counting would skip a
  // whole wrap of the prescale counter; software keeps it still then
  wire pre_term = (pre_cnt_reg == rate_reg);
  wire tick_now = run_reg & slow_en & pre_term;
  wire [`SCE_COUNT_W-1:0] count_inc = count_reg + 24'h000001;

  // Events raised this cycle
  logic [`SCE_EVT_N-1:0] evt_now;
  assign evt_now[0] = tick_now;
  assign evt_now[1] = tick_now & (count_reg == `SCE_COUNT_MAX);

  always_ff @(posedge clock or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
      pre_cnt_reg <= 12'h000;
    else if (do_clear || tick_now)
      pre_cnt_reg <= 12'h000;
    else if (run_reg && slow_en)
      pre_cnt_reg <= pre_cnt_reg + 12'h001;
  end

  // Run state: stop wins over a start in the same cycle
  always_ff @(posedge clock or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
      run_reg <= 1'b0;
    else if (do_stop)
      run_reg <= 1'b0;
    else if (do_start)
      run_reg <= 1'b1;
  end

  // Counter: tasks take priority over a tick in the same cycle
  always_ff @(posedge clock or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
      count_reg <= 24'h000000;
    else if (do_clear)
      count_reg <= 24'h000000;
    else if (do_near)
      count_reg <= `SCE_NEAR_WRAP_VAL;
    else if (tick_now)
      count_reg <= count_inc;
  end

  // Per-event flag, broadcast word and channel contribution
  logic [`SCE_CHAN_N-1:0] chan_vec [`SCE_EVT_N];
  logic [31:0] flag_rd [`SCE_EVT_N];
  logic [31:0] pub_rd [`SCE_EVT_N];

  genvar gi;
  generate
    for (gi = 0; gi < `SCE_EVT_N; gi++)
    begin : g_evt
      localparam logic [`SCE_ADDR_W-1:0] FLAG_OFS = (gi < 2) ?
        `SCE_TICK_FLAG_OFS + 12'(4 * gi) : `SCE_MATCH_FLAG_OFS + 12'(4 * (gi - 2));
      localparam logic [`SCE_ADDR_W-1:0] PUB_OFS = (gi < 2) ?
        `SCE_TICK_PUB_OFS + 12'(4 * gi) : `SCE_MATCH_PUB_OFS + 12'(4 * (gi - 2));
      wire hit_flag = (paddr == FLAG_OFS);
      wire hit_pub = (paddr == PUB_OFS);
      // A hardware event in the clearing cycle wins over the software write
      wire flag_next = evt_now[gi] | ((wr_fire & hit_flag) ? pwdata[0] : flag_reg[gi]);

      always_ff @(posedge clock or negedge rst_n_reg)
      begin
        if (!rst_n_reg)
        begin
          flag_reg[gi] <= 1'b0;
          pub_reg[gi] <= '0;
        end
        else
        begin
          flag_reg[gi] <= flag_next;
          if (wr_fire && hit_pub)
            pub_reg[gi] <= {pwdata[`SCE_PUB_EN_BIT], pwdata[`SCE_CHAN_W-1:0]};
        end
      end

      // One-hot channel drive, silent while the enable bit is 0
      assign chan_vec[gi] = (evt_now[gi] && pub_reg[gi].en) ?
        (16'h0001 << pub_reg[gi].chan) : 16'h0000;
      assign flag_rd[gi] = hit_flag ? {31'h0, flag_reg[gi]} : `SCE_ZERO_WORD;
      assign pub_rd[gi] = hit_pub ?
        {pub_reg[gi].en, 27'h0, pub_reg[gi].chan} : `SCE_ZERO_WORD;
    end
  endgenerate

  // Match values and their compare against the next count
  logic [31:0] match_rd [`SCE_MATCH_N];

  generate
    for (gi = 0; gi < `SCE_MATCH_N; gi++)
    begin : g_match
      localparam logic [`SCE_ADDR_W-1:0] VAL_OFS = `SCE_MATCH_VAL_OFS + 12'(4 * gi);
      wire hit_val = (paddr == VAL_OFS);

      always_ff @(posedge clock or negedge rst_n_reg)
      begin
        if (!rst_n_reg)
          match_reg[gi] <= 24'h000000;
        else if (wr_fire && hit_val)
          match_reg[gi] <= pwdata[`SCE_COUNT_W-1:0];
      end

      assign evt_now[gi + 2] = tick_now & (count_inc == match_reg[gi]);
      assign match_rd[gi] = hit_val ? {8'h00, match_reg[gi]} : `SCE_ZERO_WORD;
    end
  endgenerate

  // Interrupt enables set and clear by written ones; routing mask written whole, or set and clear by written ones
  always_ff @(posedge clock or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
    begin
      irq_en_reg <= 6'h00;
      route_reg <= 6'h00;
    end
    else if (wr_fire)
    begin
      if (hit_irq_set)
        irq_en_reg <= irq_en_reg | pwdata[`SCE_EVT_N-1:0];
      else if (hit_irq_clr)
        irq_en_reg <= irq_en_reg & ~pwdata[`SCE_EVT_N-1:0];
      if (hit_route)
        route_reg <= pwdata[`SCE_EVT_N-1:0];
      else if (hit_route_set)
        route_reg <= route_reg | pwdata[`SCE_EVT_N-1:0];
      else if (hit_route_clr)
        route_reg <= route_reg & ~pwdata[`SCE_EVT_N-1:0];
    end
  end

  // Rate divider, 12 bits kept, upper bits dropped
  always_ff @(posedge clock or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
      rate_reg <= 12'h000;
    else if (wr_fire && hit_rate)
      rate_reg <= pwdata[`SCE_RATE_W-1:0];
  end

  // Read data for zero-wait registers, zero for unmapped addresses
  logic [31:0] rd_mux;

  always_comb
  begin
    rd_mux = `SCE_ZERO_WORD;
    if (hit_irq_set || hit_irq_clr)
      rd_mux = {26'h0, irq_en_reg};
    else if (hit_route || hit_route_set || hit_route_clr)
      rd_mux = {26'h0, route_reg};
    else if (hit_rate)
      rd_mux = {20'h0, rate_reg};
    for (int i = 0; i < `SCE_EVT_N; i++)
      rd_mux = rd_mux | flag_rd[i] | pub_rd[i];
    for (int i = 0; i < `SCE_MATCH_N; i++)
      rd_mux = rd_mux | match_rd[i];
  end

  // Bus answer: counter reads wait three cycles while the count is sampled,
  // everything else answers in the first access cycle
  always_ff @(posedge clock or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
    begin
      wait_reg <= 2'h0;
      pready_reg <= 1'b0;
      prdata_reg <= `SCE_ZERO_WORD;
    end
    else if (is_count_rd)
    begin
      wait_reg <= `SCE_COUNT_WAIT;
      pready_reg <= 1'b0;
    end
    else if (setup_phase)
    begin
      pready_reg <= 1'b1;
      prdata_reg <= pwrite ? `SCE_ZERO_WORD : rd_mux;
    end
    else if (wait_reg != 2'h0)
    begin
      wait_reg <= wait_reg - 2'h1;
      if (wait_reg == 2'h1)
      begin
        pready_reg <= 1'b1;
        prdata_reg <= {8'h00, snap_reg};
      end
    end
    else if (access_done)
      pready_reg <= 1'b0;
  end

  // Sampled copy of the count taken in the first wait cycle, so the value
  // returned never tears against a tick landing late in the read
  always_ff @(posedge clock or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
      snap_reg <= 24'h000000;
    else if (wait_reg == `SCE_COUNT_WAIT)
      snap_reg <= count_reg;
  end

  // Outputs: interrupt level, routed event pulses, channel pulses
  logic [`SCE_CHAN_N-1:0] chan_next;

  always_comb
  begin
    chan_next = 16'h0000;
    for (int i = 0; i < `SCE_EVT_N; i++)
      chan_next = chan_next | chan_vec[i];
  end

  always_ff @(posedge clock or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
    begin
      irq_reg <= 1'b0;
      route_pulse_reg <= 6'h00;
      chan_pulse_reg <= 16'h0000;
    end
    else
    begin
      irq_reg <= |(flag_reg & irq_en_reg);
      route_pulse_reg <= evt_now & route_reg;
      chan_pulse_reg <= chan_next;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign irq = irq_reg;
  assign route_evt = sce_evt_t'(route_pulse_reg);
  assign chan_pulse = chan_pulse_reg;
  assign running = run_reg;

endmodule : sce_event_regs

// ### sce_cfg.svh
`ifndef SCE_CFG_SVH
`define SCE_CFG_SVH

// Register offsets, byte addresses on the peripheral bus
`define SCE_ADDR_W 12
`define SCE_TASK_START_OFS 12'h000
`define SCE_TASK_STOP_OFS 12'h004
`define SCE_TASK_CLEAR_OFS 12'h008
`define SCE_TASK_NEAR_WRAP_OFS 12'h00C
`define SCE_TICK_FLAG_OFS 12'h100
`define SCE_WRAP_FLAG_OFS 12'h104
`define SCE_MATCH_FLAG_OFS 12'h140
`define SCE_TICK_PUB_OFS 12'h180
`define SCE_WRAP_PUB_OFS 12'h184
`define SCE_MATCH_PUB_OFS 12'h1C0
`define SCE_IRQ_SET_OFS 12'h304
`define SCE_IRQ_CLR_OFS 12'h308
`define SCE_ROUTE_OFS 12'h340
`define SCE_ROUTE_SET_OFS 12'h344
`define SCE_ROUTE_CLR_OFS 12'h348
`define SCE_COUNT_OFS 12'h504
`define SCE_RATE_OFS 12'h508
`define SCE_MATCH_VAL_OFS 12'h540
`define SCE_STRIDE 12'h004

// Field layout
`define SCE_EVT_N 6
`define SCE_MATCH_N 4
`define SCE_CHAN_W 4
`define SCE_CHAN_N 16
`define SCE_PUB_EN_BIT 31
`define SCE_COUNT_W 24
`define SCE_RATE_W 12

// Reset and load values
`define SCE_ZERO_WORD 32'h0000_0000
`define SCE_NEAR_WRAP_VAL 24'hFFFFF0
`define SCE_COUNT_MAX 24'hFFFFFF

// Timing
`define SCE_CLK_HZ 250000000
`define SCE_SLOW_HZ 32768
`define SCE_COUNT_WAIT 2'h3

`endif

// ### sce_pkg.sv
package sce_pkg;

  // One bit per event source: tick, wrap-around, four matches
  typedef struct packed {
    logic [3:0] match;
    logic wrap;
    logic tick;
  } sce_evt_t;

  // Broadcast configuration of one event
  typedef struct packed {
    logic en;
    logic [3:0] chan;
  } sce_pub_t;

endpackage : sce_pkg

// ### sce_evt_sink.sv
`timescale 1ns/100ps
// Event channel sink: tallies the pulses seen on each broadcast channel
module sce_evt_sink
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic [15:0] chan_pulse
);
  int cnt [16];

  // Cleared with the block so totals count only this run
  always_ff @(posedge clock or negedge nrst)
  begin
    for (int i = 0; i < 16; i++)
      if (!nrst)
        cnt[i] <= 0;
      else if (chan_pulse[i])
        cnt[i] <= cnt[i] + 1;
  end
endmodule : sce_evt_sink

// ### sce_event_regs_chk.sv
`timescale 1ns/100ps
// Pin-level checks on bus timing, event pulses and reset
module sce_event_regs_chk
  import sce_pkg::*;
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic irq,
  input wire sce_evt_t route_evt,
  input wire logic [15:0] chan_pulse,
  input wire logic running
);
  default clocking cb @(posedge clock);
  endclocking

  // Bus phases used below
  sequence cnt_setup;
    psel && !penable && !pwrite && paddr == 12'h504;
  endsequence
  sequence cnt_stall;
    !pready [*3] ##1 pready;
  endsequence
  // Completed write to one address, with a qualifying data condition folded in
  sequence wr_done(a, d);
    psel && penable && pready && pwrite && paddr == a && d;
  endsequence

  AST_CNT_WAIT: assert property (disable iff (!nrst) cnt_setup |=> cnt_stall)
    else $error("counter read length wrong");
  AST_FAST_READY: assert property (disable iff (!nrst) psel && !penable && paddr != 12'h504 |=> pready)
    else $error("access stalled");
  AST_RESET_QUIET: assert property (!nrst |-> !irq && !running && route_evt == 6'h00 && chan_pulse == 16'h0000)
    else $error("outputs active in reset");
  AST_TICK_PULSE: assert property (disable iff (!nrst) route_evt.tick |=> !route_evt.tick)
    else $error("tick pulse too long");
  AST_CHAN_PULSE: assert property (disable iff (!nrst) chan_pulse != 16'h0000 |=> chan_pulse == 16'h0000)
    else $error("channel pulse too long");
  AST_STOP_QUIET: assert property (disable iff (!nrst) !running && !$past(running) |-> !route_evt.tick)
    else $error("tick while stopped");
  AST_START_RUN: assert property (disable iff (!nrst) wr_done(12'h000, pwdata[0]) |=> running)
    else $error("start ignored");
  AST_IRQ_OFF: assert property (disable iff (!nrst) wr_done(12'h308, pwdata[5:0] == 6'h3F) |=> ##1 !irq)
    else $error("irq stays after disable");
  AST_WR_ZERO: assert property (disable iff (!nrst) psel && penable && pready && pwrite |-> prdata == 32'h0)
    else $error("read data on write");
endmodule : sce_event_regs_chk

bind sce_event_regs sce_event_regs_chk i_chk (.clock(clock), .nrst(nrst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .irq(irq), .route_evt(route_evt), .chan_pulse(chan_pulse), .running(running));

// ### sce_event_regs_tb_top.sv
`timescale 1ns/100ps
// Self-checking bench for the event and configuration registers
module sce_event_regs_tb_top;
  import sce_pkg::*;
  typedef struct {logic [11:0] wa; logic [31:0] wd; logic [11:0] ra; logic [31:0] re;} sce_row_t;
  logic clock, nrst, psel, penable, pwrite, pready, irq, running;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [15:0] chan_pulse;
  sce_evt_t route_evt;
  int fail_count, num_checks, waits;
  // Write one place, read back the same place or its set/clear partner
  sce_row_t rows [9] = '{
    '{12'h304, 32'h5, 12'h308, 32'h5},
    '{12'h308, 32'h1, 12'h304, 32'h4},
    '{12'h340, 32'h3F, 12'h340, 32'h3F},
    '{12'h348, 32'h21, 12'h344, 32'h1E},
    '{12'h344, 32'h1, 12'h348, 32'h1F},
    '{12'h180, 32'h8000_0003, 12'h180, 32'h8000_0003},
    '{12'h1CC, 32'hC, 12'h1CC, 32'hC},
    '{12'h508, 32'hFFFF_FFFF, 12'h508, 32'hFFF},
    '{12'hFFC, 32'h1, 12'hFFC, 32'h0}};
  logic [11:0] zero_addr [6] = '{12'h304, 12'h340, 12'h508, 12'h180, 12'h540, 12'h104};

  // Short slow tick keeps wrap tests brief
  sce_event_regs #(.SLOW_DIV(4)) i_sce_event_regs (.clock(clock), .nrst(nrst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .irq(irq), .route_evt(route_evt), .chan_pulse(chan_pulse), .running(running));
  sce_evt_sink i_sce_evt_sink (.clock(clock), .nrst(nrst), .chan_pulse(chan_pulse));

  // 250 MHz clock
  initial
  begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic end_of_test();
    if (fail_count == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : end_of_test

  task automatic timeout();
    fail_count++;
    $display("[FAIL] %0t wait ran out", $time);
    end_of_test();
  endtask : timeout

  // One access; request held until ready, then an idle cycle so drives never collide
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel = 1'b1;
    penable = 1'b0;
    pwrite = w;
    paddr = a;
    pwdata = d;
    @(posedge clock);
    #1 penable = 1'b1;
    waits = 0;
    while (pready !== 1'b1)
    begin
      waits++;
      if (waits > 8)
        timeout();
      @(posedge clock);
      #1;
    end
    q = prdata;
    @(posedge clock);
    #1 psel = 1'b0;
    penable = 1'b0;
    @(posedge clock);
    #1;
  endtask : xfer

  // Waits for match 0 (b=1) or wrap (b=2) on the routed outputs
  task automatic wait_ev(input int b);
    int n;
    n = 0;
    while ((b == 1 ? route_evt.match[0] : route_evt.wrap) !== 1'b1)
    begin
      n++;
      if (n > 400)
        timeout();
      @(posedge clock);
      #1;
    end
  endtask : wait_ev

  // Main sequence
  initial
  begin
    nrst = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    fail_count = 0;
    num_checks = 0;
    repeat (5) @(posedge clock);
    #1 nrst = 1'b1;
    repeat (3) @(posedge clock);
    #1;
    foreach (zero_addr[i])
    begin
      xfer(1'b0, zero_addr[i], 32'h0);
      check(q, 32'h0);
    end
    foreach (rows[i])
    begin
      xfer(1'b1, rows[i].wa, rows[i].wd);
      xfer(1'b0, rows[i].ra, 32'h0);
      check(q, rows[i].re);
    end
    xfer(1'b1, 12'h508, 32'h0);
    xfer(1'b1, 12'h340, 32'h3F);
    xfer(1'b1, 12'h540, 32'h2);
    xfer(1'b1, 12'h1C0, 32'h8000_0005);
    xfer(1'b1, 12'h008, 32'h1);
    xfer(1'b1, 12'h000, 32'h1);
    wait_ev(1);
    check(chan_pulse, 32'h28);
    xfer(1'b1, 12'h004, 32'h1);
    xfer(1'b0, 12'h140, 32'h0);
    check(q, 32'h1);
    xfer(1'b0, 12'h100, 32'h0);
    check(q, 32'h1);
    check(irq, 32'h1);
    xfer(1'b1, 12'h140, 32'h0);
    check(irq, 32'h0);
    xfer(1'b1, 12'h00C, 32'h1);
    xfer(1'b0, 12'h504, 32'h0);
    check(q, 32'h00FF_FFF0);
    check(waits, 32'h3);
    xfer(1'b1, 12'h184, 32'h8000_0007);
    xfer(1'b1, 12'h000, 32'h1);
    wait_ev(2);
    check(chan_pulse, 32'h88);
    xfer(1'b1, 12'h004, 32'h1);
    xfer(1'b0, 12'h104, 32'h0);
    check(q, 32'h1);
    check(i_sce_evt_sink.cnt[5], 32'h1);
    check(i_sce_evt_sink.cnt[7], 32'h1);
    // Enable every source while flags stand, so the disable below really drops irq
    xfer(1'b1, 12'h304, 32'h3F);
    check(irq, 32'h1);
    xfer(1'b1, 12'h308, 32'h3F);
    check(irq, 32'h0);
    xfer(1'b0, 12'h304, 32'h0);
    check(q, 32'h0);
    end_of_test();
  end
endmodule : sce_event_regs_tb_top
